// ==== rtl/cfa_flag_aggregator.sv ====
// CAN interrupt flag aggregator: mailbox status bits, two line flag
// registers, masks and two interrupt lines behind an AHB-Lite slave.
// Assumes event inputs are one-cycle pulses from logic on the same clock.
// Only haddr[7:0] is decoded, so the register image repeats; hsize is
// ignored and every access is taken as a full word.
//
// Operation
// R1: Warning flag on counter reaching 96, write-one clear
// R2: Error-passive entry sets flag, write-one clear
// R3: Bus-off entry sets flag, write-one clear
// R4: Overwrite flag clears with pending-receive bit clear
// R5: Wake-up flag on leaving power-down, write-one clear
// R6: Refused mailbox write sets flag, write-one clear
// R7: Abort flag follows abort-acknowledge bits
// R8: Mailbox event flag routed by mailbox level
// R9: Timestamp top bit rising sets flag
// R10: Timeout flag follows timeout bits, mailbox-routed
// R11: System flags by global level, mailbox by own
// R12: Line released when nothing else pending
// R13: Per-mailbox level bit selects line
// R14: Per-mailbox mask; disabled mailboxes stay silent (the overwrite flag is still set for disabled or masked mailboxes)
// R15: Global mask field layout
// R16: Mailbox flag bit 15, abort 14, overwrite 11
// R17: Low five bits show mailbox number
// R18: Overwrite comes with mailbox event; lost bits
// R19: Write one clears pending-receive or transmit-acknowledge
// R20: Mailbox flag bit not writable in flag registers
// R21: Number field shows highest pending mailbox
// R22: First enabled flag activates its line
// R23: Thirty-two mailboxes, each on either line
// R24: Set beats simultaneous clear
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`include "cfa_map.svh"

module cfa_flag_aggregator (
  input  wire logic        clk,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Protocol engine events
  input  wire logic [7:0]  txErrCount,
  input  wire logic [7:0]  rxErrCount,
  input  wire logic        errPassiveEnter,
  input  wire logic        busOffEnter,
  input  wire logic        wakeupEvent,
  input  wire logic        writeDenied,
  input  wire logic [31:0] timestampCounter,
  input  wire logic [31:0] txDone,
  input  wire logic [31:0] rxDone,
  input  wire logic [31:0] abortDone,
  input  wire logic [31:0] timeoutHit,
  // Interrupt lines
  output logic             irqLine0,
  output logic             irqLine1
);

  cfa_pkg::cfa_word_t txAck_r;
  cfa_pkg::cfa_word_t rxPend_r;
  cfa_pkg::cfa_word_t abortAck_r;
  cfa_pkg::cfa_word_t lostMsg_r;
  cfa_pkg::cfa_word_t timeoutStat_r;
  cfa_pkg::cfa_word_t mbxMask_r;
  cfa_pkg::cfa_word_t mbxLevel_r;
  cfa_pkg::cfa_word_t glbMask_r;
  cfa_pkg::cfa_word_t mbxEnable_r;
  cfa_pkg::cfa_word_t sysFlag_r [2];
  cfa_pkg::cfa_word_t lineFlags [2];
  cfa_pkg::cfa_word_t lineVal   [2];
  logic               lineIrq   [2];

  logic               wrPend_r;
  logic         [7:0] wrAddr_r;
  logic               warnPrev_r;
  logic               tsMsbPrev_r;
  logic               edgeArm_r;
  logic         [31:0] hrdata_r;

  logic               addrPhase;
  logic         [7:0] wrOfs;
  cfa_pkg::cfa_word_t wrData;
  cfa_pkg::cfa_word_t txAckClr;
  cfa_pkg::cfa_word_t rxPendClr;
  cfa_pkg::cfa_word_t abortClr;
  cfa_pkg::cfa_word_t timeoutClr;
  cfa_pkg::cfa_word_t lineW1c   [2];
  cfa_pkg::cfa_word_t lostSet;
  cfa_pkg::cfa_word_t sysSet;
  logic               warnNow;
  logic               sysLine;
  logic               overwrClr;
  cfa_pkg::cfa_word_t mbxLive;

  // Highest set bit of a mailbox vector as a mailbox number
  function automatic cfa_pkg::cfa_mbx_num_t highestMbx(input cfa_pkg::cfa_word_t vec);
    cfa_pkg::cfa_mbx_num_t num;
    num = 5'h00;
    for (int i = 0; i < `CFA_NUM_MBX; i++) begin
      if (vec[i]) begin
        num = 5'(i);
      end
    end
    return num;
  endfunction

  // Register read mux, unmapped offsets read zero
  function automatic cfa_pkg::cfa_word_t readReg(input logic [7:0] ofs);
    cfa_pkg::cfa_word_t val;
    val = `CFA_RST_WORD;
    unique case (ofs)
      `CFA_OFS_TXACK:    val = txAck_r;
      `CFA_OFS_RXPEND:   val = rxPend_r;
      `CFA_OFS_ABORTACK: val = abortAck_r;
      `CFA_OFS_LOSTMSG:  val = lostMsg_r;
      `CFA_OFS_TIMEOUT:  val = timeoutStat_r;
      `CFA_OFS_MBXMASK:  val = mbxMask_r;
      `CFA_OFS_MBXLEVEL: val = mbxLevel_r;
      `CFA_OFS_GLBMASK:  val = glbMask_r;
      `CFA_OFS_LINE0:    val = lineVal[0];
      `CFA_OFS_LINE1:    val = lineVal[1];
      `CFA_OFS_MBXEN:    val = mbxEnable_r;
      default:           val = `CFA_RST_WORD;
    endcase
    return val;
  endfunction

  // Bus decode: zero-wait slave, write lands in the data phase
  assign addrPhase = hsel & htrans[1] & hready;
  assign wrOfs     = wrAddr_r;
  assign wrData    = wrPend_r ? hwdata : `CFA_RST_WORD;

  // Data-phase tracking; address kept for the write decode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end else if (hready) begin
      wrPend_r <= addrPhase & hwrite;
      wrAddr_r <= haddr[7:0];
    end
  end

  // Read data captured at the address phase
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hrdata_r <= `CFA_RST_WORD;
    end else if (addrPhase & ~hwrite) begin
      hrdata_r <= readReg(haddr[7:0]);
    end
  end

  // Ready from the first edge after reset, always OKAY
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read data straight from its flip-flop
  assign hrdata = hrdata_r;

  // Write-one-clear strobes for status bits
  assign txAckClr   = (wrOfs == `CFA_OFS_TXACK)    ? wrData : `CFA_RST_WORD; // R19
  assign rxPendClr  = (wrOfs == `CFA_OFS_RXPEND)   ? wrData : `CFA_RST_WORD; // R19
  assign abortClr   = (wrOfs == `CFA_OFS_ABORTACK) ? wrData : `CFA_RST_WORD;
  assign timeoutClr = (wrOfs == `CFA_OFS_TIMEOUT)  ? wrData : `CFA_RST_WORD;
  // Mailbox flag bit is outside the write mask
  assign lineW1c[0] = (wrOfs == `CFA_OFS_LINE0) ? (wrData & `CFA_GIF_W1CMASK) : 32'h0; // R20
  assign lineW1c[1] = (wrOfs == `CFA_OFS_LINE1) ? (wrData & `CFA_GIF_W1CMASK) : 32'h0; // R20

  // Mailbox status bits, set beats clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txAck_r       <= `CFA_RST_WORD;
      rxPend_r      <= `CFA_RST_WORD;
      abortAck_r    <= `CFA_RST_WORD;
      timeoutStat_r <= `CFA_RST_WORD;
    end else begin
      txAck_r       <= (txAck_r & ~txAckClr) | txDone;             // R19 R24
      rxPend_r      <= (rxPend_r & ~rxPendClr) | rxDone;           // R19 R24
      abortAck_r    <= (abortAck_r & ~abortClr) | abortDone;       // R7 R24
      timeoutStat_r <= (timeoutStat_r & ~timeoutClr) | timeoutHit; // R10 R24
    end
  end

  // Overwrite: reception into a still-pending mailbox
  assign lostSet   = rxDone & rxPend_r; // R18
  assign overwrClr = |(rxPendClr & lostMsg_r); // R4

  // Lost-message bits name the overwritten mailbox
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lostMsg_r <= `CFA_RST_WORD;
    end else begin
      lostMsg_r <= (lostMsg_r & ~rxPendClr) | lostSet; // R18 R24
    end
  end

  // Software configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mbxMask_r   <= `CFA_RST_WORD;
      mbxLevel_r  <= `CFA_RST_WORD;
      glbMask_r   <= `CFA_RST_WORD;
      mbxEnable_r <= `CFA_RST_WORD;
    end else if (wrPend_r) begin
      if (wrOfs == `CFA_OFS_MBXMASK) begin
        mbxMask_r <= hwdata; // R14
      end
      if (wrOfs == `CFA_OFS_MBXLEVEL) begin
        mbxLevel_r <= hwdata; // R13
      end
      if (wrOfs == `CFA_OFS_GLBMASK) begin
        glbMask_r <= hwdata & `CFA_GIM_WMASK; // R15
      end
      if (wrOfs == `CFA_OFS_MBXEN) begin
        mbxEnable_r <= hwdata; // R14
      end
    end
  end

  // Mailboxes allowed to interrupt: unmasked and enabled
  assign mbxLive = mbxMask_r & mbxEnable_r; // R14

  // Edge detectors for warning level and timestamp top bit
  assign warnNow = (txErrCount >= `CFA_WARN_LEVEL) | (rxErrCount >= `CFA_WARN_LEVEL); // R1

  // Previous levels of the edge-detected inputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      warnPrev_r  <= 1'b0;
      tsMsbPrev_r <= 1'b0;
    end else begin
      warnPrev_r  <= warnNow;
      tsMsbPrev_r <= timestampCounter[31];
    end
  end

  // Timestamp edge armed one edge after reset: a counter already past
  // its top bit at release must not look like an overflow
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      edgeArm_r <= 1'b0;
    end else begin
      edgeArm_r <= 1'b1;
    end
  end

  // System event set vector in flag-register positions
  always_comb begin
    sysSet = `CFA_RST_WORD;
    sysSet[`CFA_GIF_WARN]    = warnNow & ~warnPrev_r;                    // R1
    sysSet[`CFA_GIF_ERRPASS] = errPassiveEnter;                         // R2
    sysSet[`CFA_GIF_BUSOFF]  = busOffEnter;                             // R3
    sysSet[`CFA_GIF_OVERWR]  = |lostSet;                                // R4 R18
    sysSet[`CFA_GIF_WAKEUP]  = wakeupEvent;                             // R5
    sysSet[`CFA_GIF_WRDENY]  = writeDenied;                             // R6
    sysSet[`CFA_GIF_TSOVF]   = edgeArm_r & timestampCounter[31] & ~tsMsbPrev_r; // R9
  end

  // System flags follow the global level bit
  assign sysLine = glbMask_r[`CFA_GIM_SYSLINE]; // R11

  // Per-line logic: sticky system flags, derived flags, line output
  generate
    for (genvar ln = 0; ln < 2; ln++) begin : gLine
      cfa_pkg::cfa_word_t lineSel;
      cfa_pkg::cfa_word_t mbxAct;
      cfa_pkg::cfa_word_t setHere;
      cfa_pkg::cfa_word_t ovrKill;
      cfa_pkg::cfa_word_t enVec;

      // Mailboxes whose level bit picks this line
      assign lineSel = (ln == 1) ? mbxLevel_r : ~mbxLevel_r; // R11 R13 R23
      assign mbxAct  = (txAck_r | rxPend_r) & mbxLive & lineSel; // R8 R14
      assign setHere = ((sysLine == 1'(ln)) ? sysSet : 32'h0); // R11
      assign ovrKill = overwrClr ? (32'h1 << `CFA_GIF_OVERWR) : 32'h0; // R4

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          sysFlag_r[ln] <= `CFA_RST_WORD;
        end else begin
          sysFlag_r[ln] <= (sysFlag_r[ln] & ~lineW1c[ln] & ~ovrKill) | setHere; // R24
        end
      end

      // Visible flag bits of this line
      always_comb begin
        lineFlags[ln] = sysFlag_r[ln] & `CFA_GIF_W1CMASK;
        lineFlags[ln][`CFA_GIF_OVERWR] = sysFlag_r[ln][`CFA_GIF_OVERWR];
        lineFlags[ln][`CFA_GIF_ABORT]  = (|(abortAck_r & mbxEnable_r)) & (sysLine == 1'(ln)); // R7 R14
        lineFlags[ln][`CFA_GIF_MBX]    = |mbxAct; // R8 R16
        lineFlags[ln][`CFA_GIF_TMOUT]  = |(timeoutStat_r & mbxEnable_r & lineSel); // R10 R14
      end

      // Read value with the pending mailbox number in the low bits
      always_comb begin
        lineVal[ln] = lineFlags[ln];
        lineVal[ln][`CFA_GIF_MIV_HI:0] = highestMbx(mbxAct); // R17 R21
      end

      // Enable vector aligned to the flag positions
      always_comb begin
        enVec = `CFA_RST_WORD;
        enVec[`CFA_GIF_WARN]    = glbMask_r[`CFA_GIM_WARN];    // R15
        enVec[`CFA_GIF_ERRPASS] = glbMask_r[`CFA_GIM_ERRPASS]; // R15
        enVec[`CFA_GIF_BUSOFF]  = glbMask_r[`CFA_GIM_BUSOFF];  // R15
        enVec[`CFA_GIF_OVERWR]  = glbMask_r[`CFA_GIM_OVERWR];  // R15
        enVec[`CFA_GIF_WAKEUP]  = glbMask_r[`CFA_GIM_WAKEUP];  // R15
        enVec[`CFA_GIF_WRDENY]  = glbMask_r[`CFA_GIM_WRDENY];  // R15
        enVec[`CFA_GIF_ABORT]   = glbMask_r[`CFA_GIM_ABORT];   // R15
        enVec[`CFA_GIF_MBX]     = 1'b1;                        // R14
        enVec[`CFA_GIF_TSOVF]   = glbMask_r[`CFA_GIM_TSOVF];
        enVec[`CFA_GIF_TMOUT]   = glbMask_r[`CFA_GIM_TMOUT];
      end

      // Line asserts while its enable bit is set and any enabled flag is pending
      assign lineIrq[ln] = glbMask_r[ln] & (|(lineFlags[ln] & enVec)); // R12 R22
    end
  endgenerate

  // Interrupt outputs straight from flip-flops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irqLine0 <= 1'b0;
      irqLine1 <= 1'b0;
    end else begin
      irqLine0 <= lineIrq[0]; // R12 R22
      irqLine1 <= lineIrq[1]; // R12 R22
    end
  end

endmodule

// ==== rtl/cfa_map.svh ====
// Register offsets, field positions and reset values of the flag aggregator.
// Assumes byte addresses on a 32-bit AHB-Lite bus, one register per word.
`ifndef CFA_MAP_SVH
`define CFA_MAP_SVH

// Mailbox count and error-counter warning threshold (96)
`define CFA_NUM_MBX      32
`define CFA_WARN_LEVEL   8'h60

// Register byte offsets, decoded on haddr[7:0]
`define CFA_OFS_TXACK    8'h00
`define CFA_OFS_RXPEND   8'h04
`define CFA_OFS_ABORTACK 8'h08
`define CFA_OFS_LOSTMSG  8'h0c
`define CFA_OFS_TIMEOUT  8'h10
`define CFA_OFS_MBXMASK  8'h14
`define CFA_OFS_MBXLEVEL 8'h18
`define CFA_OFS_GLBMASK  8'h1c
`define CFA_OFS_LINE0    8'h20
`define CFA_OFS_LINE1    8'h24
`define CFA_OFS_MBXEN    8'h28

// Global mask register fields
`define CFA_GIM_LINE0EN  0
`define CFA_GIM_LINE1EN  1
`define CFA_GIM_SYSLINE  2
`define CFA_GIM_WARN     8
`define CFA_GIM_ERRPASS  9
`define CFA_GIM_BUSOFF   10
`define CFA_GIM_OVERWR   11
`define CFA_GIM_WAKEUP   12
`define CFA_GIM_WRDENY   13
`define CFA_GIM_ABORT    14
`define CFA_GIM_TSOVF    15
`define CFA_GIM_TMOUT    16
`define CFA_GIM_WMASK    32'h0001ff07

// Line flag register fields
`define CFA_GIF_MIV_HI   4
`define CFA_GIF_WARN     8
`define CFA_GIF_ERRPASS  9
`define CFA_GIF_BUSOFF   10
`define CFA_GIF_OVERWR   11
`define CFA_GIF_WAKEUP   12
`define CFA_GIF_WRDENY   13
`define CFA_GIF_ABORT    14
`define CFA_GIF_MBX      15
`define CFA_GIF_TSOVF    16
`define CFA_GIF_TMOUT    17
`define CFA_GIF_W1CMASK  32'h00013f00

// Reset values
`define CFA_RST_WORD     32'h00000000

`endif

// ==== rtl/cfa_pkg.sv ====
// Types shared by the flag aggregator and its bench.
// Assumes cfa_map.svh supplies all numeric constants.
package cfa_pkg;
  typedef logic [31:0] cfa_word_t;
  typedef logic [4:0]  cfa_mbx_num_t;
endpackage

// ==== test/cfa_host_model.sv ====
// Host-side register software: a single-word bus master.
// Assumes hready is the slave's hreadyout on a one-slave bus.
`timescale 1ns/10ps
module cfa_host_model (
  input  wire logic        clk,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  // Idle bus from time zero
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h00000000;
  end

  // Address phase held until taken, then data phase until taken
  task automatic xfer(input logic w, input logic [7:0] a, input cfa_pkg::cfa_word_t wd,
                      output cfa_pkg::cfa_word_t rd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
endmodule

// ==== test/cfa_monitor.sv ====
// Checker of interrupt lines and register reads of the flag aggregator.
// Assumes a zero-wait bus slave and one-cycle event pulses.
`timescale 1ns/10ps
module cfa_monitor (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        busOffEnter,
  input wire logic [31:0] txDone,
  input wire logic [31:0] rxDone,
  input wire logic        irqLine0,
  input wire logic        irqLine1
);
  logic        wrPend;
  logic        rdPend;
  logic [7:0]  ofs;
  logic [31:0] gimR;
  logic [31:0] milR;
  logic [31:0] mimR;
  logic [31:0] menR;
  logic [31:0] mbxEv;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Shadow of bus phases and configuration words
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      ofs    <= 8'h00;
      gimR   <= 32'h00000000;
      milR   <= 32'h00000000;
      mimR   <= 32'h00000000;
      menR   <= 32'h00000000;
    end else begin
      if (wrPend && ofs == 8'h1c) gimR <= hwdata & 32'h0001ff07;
      if (wrPend && ofs == 8'h18) milR <= hwdata;
      if (wrPend && ofs == 8'h14) mimR <= hwdata;
      if (wrPend && ofs == 8'h28) menR <= hwdata;
      if (hsel && htrans[1] && hready) ofs <= haddr[7:0];
      wrPend <= hsel && htrans[1] && hready && hwrite;
      rdPend <= hsel && htrans[1] && hready && !hwrite;
    end
  end

  // Completions of unmasked, enabled mailboxes
  assign mbxEv = (txDone | rxDone) & mimR & menR;

  gim_read_a: assert property (rdPend && ofs == 8'h1c |-> hrdata == $past(gimR))
    else $error("mask register readback differs");
  flag_pad_a: assert property (rdPend && ofs[7:3] == 5'h04 |->
    hrdata[31:18] == 14'h0000 && hrdata[7:5] == 3'h0)
    else $error("flag register unused bits set");
  mbx_line0_a: assert property (|(mbxEv & ~milR) && gimR[0] |-> ##2 irqLine0)
    else $error("mailbox event missed line 0");
  mbx_line1_a: assert property (|(mbxEv & milR) && gimR[1] |-> ##2 irqLine1)
    else $error("mailbox event missed line 1");
  sys_line_a: assert property (busOffEnter && gimR[10] && gimR[gimR[2]] |->
    ##2 (gimR[2] ? irqLine1 : irqLine0))
    else $error("system event on wrong line");
  gate_line0_a: assert property (irqLine0 |-> gimR[0] || $past(gimR[0]))
    else $error("line 0 active while disabled");
  gate_line1_a: assert property (irqLine1 |-> gimR[1] || $past(gimR[1]))
    else $error("line 1 active while disabled");
  line_release_a: assert property ($fell(irqLine0) || $fell(irqLine1) |->
    $past(wrPend, 2) || $past(wrPend, 3))
    else $error("line dropped without a write");
endmodule

bind cfa_flag_aggregator cfa_monitor u_mon (
  .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .busOffEnter(busOffEnter), .txDone(txDone), .rxDone(rxDone),
  .irqLine0(irqLine0), .irqLine1(irqLine1)
);

// ==== test/tb_top.sv ====
// Self-checking bench of the flag aggregator through its register bus.
// Assumes the host model masters the bus and the monitor is bound in.
`timescale 1ns/10ps
module tb_top;
  logic               clk;
  logic               reset;
  logic               hsel;
  logic               hwrite;
  logic               hreadyout;
  logic               hresp;
  logic               irqLine0;
  logic               irqLine1;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [7:0]         txErr;
  logic [7:0]         rxErr;
  logic [3:0]         sysEv;
  logic [31:0]        haddr;
  logic [31:0]        hwdata;
  logic [31:0]        hrdata;
  logic [31:0]        txDone;
  logic [31:0]        rxDone;
  logic [31:0]        abortDone;
  logic [31:0]        timeoutHit;
  logic [31:0]        tsCount;
  cfa_pkg::cfa_word_t rdv;
  int                 failCount;
  int                 totalChecks;
  int                 cyc;
  int                 pos [4] = '{9, 10, 12, 13};

  cfa_flag_aggregator u_dut (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .txErrCount(txErr), .rxErrCount(rxErr), .errPassiveEnter(sysEv[0]),
    .busOffEnter(sysEv[1]), .wakeupEvent(sysEv[2]), .writeDenied(sysEv[3]),
    .timestampCounter(tsCount), .txDone(txDone), .rxDone(rxDone),
    .abortDone(abortDone), .timeoutHit(timeoutHit),
    .irqLine0(irqLine0), .irqLine1(irqLine1)
  );
  cfa_host_model u_host (
    .clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata)
  );

  // Clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rdv);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    u_host.xfer(1'b0, a, 32'h00000000, rdv);
    chk(rdv, e);
  endtask

  // One-cycle event pulse, then time for flags and lines to settle
  task automatic ev(input int k, input int n);
    case (k)
      0: txDone[n] <= 1'b1;
      1: rxDone[n] <= 1'b1;
      2: abortDone[n] <= 1'b1;
      3: timeoutHit[n] <= 1'b1;
      default: sysEv[n] <= 1'b1;
    endcase
    @(posedge clk);
    {txDone, rxDone, abortDone, timeoutHit} <= '0;
    sysEv <= 4'h0;
    repeat (2) @(posedge clk);
  endtask

  // Line levels one edge on, once settled
  task automatic lines(input logic [1:0] e);
    @(posedge clk);
    @(negedge clk);
    chk({30'h0, irqLine1, irqLine0}, {30'h0, e});
    @(posedge clk);
  endtask

  // Cycle ceiling against a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      failCount++;
      summarize();
    end
  end

  initial begin
    reset = 1'b1;
    {txDone, rxDone, abortDone, timeoutHit, tsCount} = '0;
    txErr = 8'h00;
    rxErr = 8'h00;
    sysEv = 4'h0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // Reset contents, unmapped word, mask layout
    for (int a = 0; a <= 'h2c; a += 4) rd(a[7:0], 32'h0);
    wr(8'h1c, 32'hffffffff);
    rd(8'h1c, 32'h0001ff07);
    wr(8'h1c, 32'h0001ff03);
    wr(8'h14, 32'hffffefff);
    wr(8'h18, 32'h00000008);
    wr(8'h28, 32'hffffffff);
    // Mailbox events, number field, clears
    ev(0, 3);
    lines(2'b10);
    rd(8'h24, 32'h00008003);
    ev(1, 5);
    ev(1, 9);
    rd(8'h20, 32'h00008009);
    lines(2'b11);
    wr(8'h20, 32'h00008000);
    rd(8'h20, 32'h00008009);
    wr(8'h04, 32'h00000200);
    rd(8'h20, 32'h00008005);
    ev(1, 12);
    rd(8'h04, 32'h00001020);
    rd(8'h20, 32'h00008005);
    wr(8'h04, 32'hffffffff);
    rd(8'h20, 32'h00000000);
    lines(2'b10);
    wr(8'h00, 32'h00000008);
    lines(2'b00);
    // System flags on line 0, write-one clear
    for (int i = 0; i < 4; i++) begin
      ev(4, i);
      rd(8'h20, 32'h1 << pos[i]);
      lines(2'b01);
      wr(8'h20, 32'h1 << pos[i]);
      rd(8'h20, 32'h00000000);
    end
    // Overwrite, then abort
    ev(1, 2);
    ev(1, 2);
    rd(8'h0c, 32'h00000004);
    rd(8'h20, 32'h00008802);
    wr(8'h04, 32'h00000004);
    rd(8'h20, 32'h00000000);
    rd(8'h0c, 32'h00000000);
    ev(2, 7);
    rd(8'h08, 32'h00000080);
    rd(8'h20, 32'h00004000);
    wr(8'h08, 32'h00000080);
    rd(8'h20, 32'h00000000);
    // Reception in the very cycle of its clear: the set survives
    ev(1, 6);
    fork
      wr(8'h04, 32'h00000040);
      begin
        @(posedge clk);
        rxDone[6] <= 1'b1;
        @(posedge clk);
        rxDone[6] <= 1'b0;
      end
    join
    rd(8'h04, 32'h00000040);
    rd(8'h20, 32'h00008806);
    wr(8'h04, 32'h00000040);
    rd(8'h20, 32'h00000000);
    // System line 1: warning, timestamp; timeout on line 1 by mailbox 3 level bit
    wr(8'h1c, 32'h0001ff07);
    ev(3, 3);
    rd(8'h24, 32'h00020000);
    wr(8'h10, 32'h00000008);
    rd(8'h24, 32'h00000000);
    txErr <= 8'd96;
    repeat (3) @(posedge clk);
    rd(8'h24, 32'h00000100);
    lines(2'b10);
    txErr <= 8'd0;
    wr(8'h24, 32'h00000100);
    rd(8'h24, 32'h00000000);
    tsCount <= 32'h80000000;
    repeat (3) @(posedge clk);
    rd(8'h24, 32'h00010000);
    wr(8'h24, 32'h00010000);
    rd(8'h24, 32'h00000000);
    lines(2'b00);
    chk({31'h0, hresp}, 32'h0);
    summarize();
  end
endmodule
